// [bank_core_model.sv]
// core-side stand-in issuing data memory accesses over apb
// assumes a free-running pclk
`timescale 1ns/1ps
module bank_core_model (
    input  wire logic        pclk,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [11:0] paddr,
    output logic      [31:0] pwdata
);
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        // released lines show the inverse
        {psel, penable, paddr, pwdata} <= {2'b00, ~a, ~d};
    endtask
endmodule // bank_core_model

// [bank_mem_pkg.sv]
// constants for the banked data memory with indirect access
// assumes an APB master with 32-bit data; one data location per aligned word
package bank_mem_pkg;

    localparam int DATA_W     = 8;
    localparam int APB_AW     = 12;
    localparam int WORD_SHIFT = 2;
    localparam int GP_DEPTH   = 128;
    localparam int IDX_W      = 9;

    // data memory locations (index; byte address is four times this)
    localparam logic [7:0] LOC_PORT_B0  = 8'h00;
    localparam logic [7:0] LOC_PTR_B0   = 8'h01;
    localparam logic [7:0] LOC_PORT_ANY = 8'h02;
    localparam logic [7:0] LOC_PTR_ANY  = 8'h03;
    localparam logic [7:0] LOC_BANK_SEL = 8'h04;
    localparam logic [7:0] LOC_STATUS   = 8'h05;
    localparam logic [7:0] LOC_NVM_CTRL = 8'h40;
    localparam logic [7:0] LOC_GP_BASE  = 8'h80;

    localparam logic [7:0] BANK_DIRECT  = 8'h00;
    localparam logic [7:0] BANK_NVM     = 8'h01;

    // status field positions
    localparam int STAT_BANK_OK_BIT = 0;
    localparam int STAT_DISCARD_BIT = 1;

    // reset values
    localparam logic [7:0] RST_PTR    = 8'h00;
    localparam logic [7:0] RST_BANK   = 8'h00;
    localparam logic [7:0] RST_NVM    = 8'h00;
    localparam logic [7:0] RST_DATA   = 8'h00;
    localparam logic [7:0] READ_EMPTY = 8'h00;

endpackage

// [bank_mem_props.sv]
// assertions on the data memory apb port
// sees only the top ports; bound at the foot
`timescale 1ns/1ps
module bank_mem_props (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [7:0]  bank_select_pointer,
    input wire logic [7:0]  nvm_control_register
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire wr_ok = pready && pwrite;
    wire rd_ok = pready && !pwrite && !pslverr;
    sequence s_setup; psel && !penable; endsequence
    sequence s_wait; psel && penable && !pready; endsequence
    property p_early; s_setup |=> !pready; endproperty
    property p_done; s_setup ##1 s_wait |=> pready; endproperty
    property p_err; pready |-> pslverr == (paddr[1:0] != 2'h0 || paddr[11:10] != 2'h0);
    endproperty
    property p_width; pready |-> prdata[31:8] == 24'h0; endproperty
    property p_bs_wr; wr_ok && paddr == 12'h010 |=> bank_select_pointer == $past(pwdata[7:0]);
    endproperty
    property p_bs_keep; !$stable(bank_select_pointer) |-> $past(wr_ok); endproperty
    property p_bs_rd; rd_ok && paddr == 12'h010 |-> prdata[7:0] == bank_select_pointer;
    endproperty
    property p_nv_keep; !$stable(nvm_control_register) |->
        $past(wr_ok) && $past(bank_select_pointer) == 8'h01; endproperty
    property p_nv_rd; rd_ok && paddr == 12'h100 |->
        prdata[7:0] == (bank_select_pointer == 8'h01 ? nvm_control_register : 8'h00); endproperty
    a_early: assert property (p_early) else $error("early ready");
    a_done: assert property (p_done) else $error("no ready");
    a_err: assert property (p_err) else $error("error flag");
    a_width: assert property (p_width) else $error("upper data");
    a_bs_wr: assert property (p_bs_wr) else $error("bank write");
    a_bs_keep: assert property (p_bs_keep) else $error("bank moved");
    a_bs_rd: assert property (p_bs_rd) else $error("bank read");
    a_nv_keep: assert property (p_nv_keep) else $error("nvm moved");
    a_nv_rd: assert property (p_nv_rd) else $error("nvm read");
endmodule // bank_mem_props
bind banked_data_memory bank_mem_props chk_u (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .bank_select_pointer, .nvm_control_register);

// [banked_data_memory.sv]
// banked data memory with two pointer/indirect-port pairs, APB slave
// assumes synchronous APB inputs on pclk; one wait state per access
//
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module banked_data_memory
    import bank_mem_pkg::*;
#(
    parameter int NUM_BANKS = 3
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [APB_AW-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic      [7:0]        bank_select_pointer,
    output logic      [7:0]        nvm_control_register
);

    localparam int GP_WORDS = NUM_BANKS * GP_DEPTH;

    // answer state of the bus handshake
    typedef enum logic {
        BUS_OPEN   = 1'b0,
        BUS_ANSWER = 1'b1
    } bus_state_t;

    // bank value names an implemented bank
    function automatic logic bank_ok(input logic [7:0] bank);
        bank_ok = (bank < 8'(NUM_BANKS));
    endfunction

    function automatic logic [IDX_W-1:0] gp_index(input logic [7:0] bank,
                                                  input logic [7:0] addr);
        gp_index = {bank[1:0], addr[6:0]};
    endfunction

    function automatic logic gp_hit(input logic [7:0] bank, input logic [7:0] addr);
        gp_hit = (addr >= LOC_GP_BASE) && bank_ok(bank);
    endfunction

    // the two port locations, never storage
    function automatic logic is_port(input logic [7:0] addr);
        is_port = (addr == LOC_PORT_B0) || (addr == LOC_PORT_ANY);
    endfunction

    logic [DATA_W-1:0] mem_r   [0:GP_WORDS-1];
    logic [DATA_W-1:0] mem_nxt [0:GP_WORDS-1];
    logic [7:0]        ptr_b0_r, ptr_b0_nxt;
    logic [7:0]        ptr_any_r, ptr_any_nxt;
    logic [7:0]        bank_r, bank_nxt;
    logic [7:0]        nvm_r, nvm_nxt;
    logic              discard_r, discard_nxt;
    bus_state_t        bus_r, bus_nxt;
    logic              err_r, err_nxt;
    logic [7:0]        rdata_r, rdata_nxt;
    logic              mem_we;
    logic [IDX_W-1:0]  mem_idx;
    logic [7:0]        loc;
    logic              addr_ok;
    logic              indirect;
    logic [7:0]        tgt_bank;
    logic [7:0]        tgt_addr;
    logic              port_hit;
    logic              access_first;
    logic              wr_fire;
    logic              sel_ptr_b0;
    logic              sel_ptr_any;
    logic              sel_bank;
    logic              sel_nvm;
    logic              sel_gp;
    logic [7:0]        status;
    logic [7:0]        rd_val;
    logic [7:0]        wdata;

    assign pready               = psel & penable & (bus_r == BUS_ANSWER);
    assign pslverr              = pready & err_r;
    assign prdata               = {24'h000000, rdata_r};
    assign bank_select_pointer  = bank_r;
    assign nvm_control_register = nvm_r;
    assign access_first         = psel & penable & (bus_r == BUS_OPEN);

    // address decode and redirection through the pointers
    always_comb begin
        // location 00H is the first word
        loc     = paddr[WORD_SHIFT+7:WORD_SHIFT];
        addr_ok = (paddr[APB_AW-1:WORD_SHIFT+8] == '0) && (paddr[WORD_SHIFT-1:0] == '0);
        wdata   = pwdata[7:0];

        unique case (loc)
            LOC_PORT_B0: begin
                // first port fixed on bank 0
                indirect = 1'b1;
                tgt_bank = BANK_DIRECT;
                tgt_addr = ptr_b0_r;
            end
            LOC_PORT_ANY: begin
                indirect = 1'b1;
                tgt_bank = bank_r;
                tgt_addr = ptr_any_r;
            end
            default: begin
                // direct general-purpose access is bank 0
                indirect = 1'b0;
                tgt_bank = (loc < LOC_GP_BASE) ? bank_r : BANK_DIRECT;
                tgt_addr = loc;
            end
        endcase

        port_hit = indirect && is_port(tgt_addr);
    end

    // status word built from live state
    always_comb begin
        status                   = 8'h00;
        status[STAT_BANK_OK_BIT] = bank_ok(bank_r);
        status[STAT_DISCARD_BIT] = discard_r;
    end

    // read multiplexer
    always_comb begin
        rd_val = READ_EMPTY;
        if (!port_hit) begin
            unique case (tgt_addr)
                LOC_PTR_B0:   rd_val = ptr_b0_r;
                LOC_PTR_ANY:  rd_val = ptr_any_r;
                LOC_BANK_SEL: rd_val = bank_r;
                LOC_STATUS:   rd_val = status;
                // control at 40H in bank 1 only
                LOC_NVM_CTRL: rd_val = (tgt_bank == BANK_NVM) ? nvm_r : READ_EMPTY;
                default: begin
                    if (gp_hit(tgt_bank, tgt_addr)) begin
                        rd_val = mem_r[gp_index(tgt_bank, tgt_addr)];
                    end
                end
            endcase
        end
    end

    // bus group: one wait cycle, data captured in it
    always_comb begin
        bus_nxt   = BUS_OPEN;
        err_nxt   = err_r;
        rdata_nxt = rdata_r;

        unique case (bus_r)
            BUS_OPEN: begin
                if (access_first) begin
                    bus_nxt   = BUS_ANSWER;
                    err_nxt   = ~addr_ok;
                    rdata_nxt = (addr_ok && !pwrite) ? rd_val : READ_EMPTY;
                end
            end
            BUS_ANSWER: begin
                bus_nxt = BUS_OPEN;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_r   <= BUS_OPEN;
            err_r   <= 1'b0;
            rdata_r <= READ_EMPTY;
        end else begin
            bus_r   <= bus_nxt;
            err_r   <= err_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // write strobe and one-hot target selection
    always_comb begin
        wr_fire     = pready & pwrite & ~err_r;
        sel_ptr_b0  = 1'b0;
        sel_ptr_any = 1'b0;
        sel_bank    = 1'b0;
        sel_nvm     = 1'b0;
        sel_gp      = 1'b0;

        if (wr_fire && !port_hit) begin
            unique case (tgt_addr)
                LOC_PTR_B0:   sel_ptr_b0  = 1'b1;
                LOC_PTR_ANY:  sel_ptr_any = 1'b1;
                // bank set only from software write
                LOC_BANK_SEL: sel_bank    = 1'b1;
                LOC_STATUS:   ;
                // control written in bank 1 only
                LOC_NVM_CTRL: sel_nvm     = (tgt_bank == BANK_NVM);
                default:      sel_gp      = gp_hit(tgt_bank, tgt_addr);
            endcase
        end
    end

    // first pointer group
    always_comb begin
        ptr_b0_nxt = ptr_b0_r;
        if (sel_ptr_b0) begin
            ptr_b0_nxt = wdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ptr_b0_r <= RST_PTR;
        end else begin
            ptr_b0_r <= ptr_b0_nxt;
        end
    end

    // second pointer group
    always_comb begin
        ptr_any_nxt = ptr_any_r;
        if (sel_ptr_any) begin
            ptr_any_nxt = wdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ptr_any_r <= RST_PTR;
        end else begin
            ptr_any_r <= ptr_any_nxt;
        end
    end

    // bank select group
    always_comb begin
        bank_nxt = bank_r;
        if (sel_bank) begin
            bank_nxt = wdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bank_r <= RST_BANK;
        end else begin
            bank_r <= bank_nxt;
        end
    end

    // nonvolatile-memory control group
    always_comb begin
        nvm_nxt = nvm_r;
        if (sel_nvm) begin
            nvm_nxt = wdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nvm_r <= RST_NVM;
        end else begin
            nvm_r <= nvm_nxt;
        end
    end

    // write to a pointed port is dropped
    always_comb begin
        discard_nxt = discard_r;
        if (wr_fire) begin
            discard_nxt = port_hit;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            discard_r <= 1'b0;
        end else begin
            discard_r <= discard_nxt;
        end
    end

    // general-purpose memory group
    always_comb begin
        mem_we  = sel_gp;
        mem_idx = gp_index(tgt_bank, tgt_addr);
        mem_nxt = mem_r;
        if (mem_we) begin
            mem_nxt[mem_idx] = wdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < GP_WORDS; i++) begin
                mem_r[i] <= RST_DATA;
            end
        end else begin
            mem_r <= mem_nxt;
        end
    end

endmodule // banked_data_memory

// [banked_data_memory_indirect_access_test.sv]
// random data memory traffic checked against a behavioural model
// assumes the core model drives apb; three banks
`timescale 1ns/1ps
module banked_data_memory_indirect_access_test;
    localparam int NB = 3;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [7:0]  bank_select_pointer, nvm_control_register;
    int          bad_count, samples_checked, seed, disc, md[1024];
    banked_data_memory #(.NUM_BANKS(NB)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .bank_select_pointer, .nvm_control_register);
    bank_core_model m_u (.pclk, .prdata, .pready, .pslverr, .psel, .penable, .pwrite,
        .paddr, .pwdata);
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    // resolve a location to a model slot; -1 empty, -2 status
    function automatic int key(input int a);
        int gb, sb;
        gb = 0;
        sb = md[4];
        // first port bank 0, second port selected bank
        if (a == 0) begin
            a = md[1];
            sb = 0;
        end else if (a == 2) begin
            a = md[3];
            gb = sb;
        end
        if (a == 0 || a == 2) return -3;
        if (a == 5) return -2;
        if (a >= 128) return (gb < NB) ? gb * 256 + a : -1;
        // nvm control in bank 1 only
        if (a == 64) return (sb == 1) ? 64 : -1;
        return (a inside {1, 3, 4}) ? a : -1;
    endfunction
    task automatic chk(input string n, input int x, input logic [31:0] g);
        samples_checked++;
        if (g !== 32'(x)) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic acc(input logic w, input int a, input int d);
        int k;
        k = key(a);
        m_u.xfer(w, 12'(a * 4), 32'(d), r, e);
        chk("pslverr", 0, {31'h0, e});
        if (w && k >= 0) md[k] = d & 255;
        if (w) disc = (k == -3);
        if (!w) chk("prdata", k == -2 ? disc * 2 + (md[4] < NB) : k < 0 ? 0 : md[k], r);
        if (w) begin
            @(negedge pclk);
            chk("bank", md[4], {24'h0, bank_select_pointer});
            chk("nvm", md[64], {24'h0, nvm_control_register});
        end
    endtask
    task results;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        int op, a;
        int pick[8] = '{0, 1, 2, 3, 4, 64, 128, 5};
        seed = 32'h0E51;
        disc = 0;
        presetn = 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        acc(0, 4, 0);
        acc(1, 1, 8'h85);
        acc(1, 0, 8'h5A);
        acc(0, 8'h85, 0);
        repeat (600) begin
            op = $random(seed);
            a = pick[op[2:0]];
            if (a == 128) a = a + op[14:8];
            acc(op[3], a, a == 4 ? op[17:16] : op[31:24]);
        end
        m_u.xfer(1, 12'h401, 32'h0, r, e);
        chk("bad pslverr", 1, {31'h0, e});
        results();
    end
    initial begin
        repeat (8000) @(posedge pclk);
        bad_count++;
        results();
    end
endmodule // banked_data_memory_indirect_access_test
